// File: inc/timer_evt_pkg.sv
// Package: offsets, field layout and reset values of the timer event block
package timer_evt_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTL    = 8'h00;
   localparam logic [7:0] OFS_CTL1   = 8'h04;
   localparam logic [7:0] OFS_INTEN  = 8'h0C;
   localparam logic [7:0] OFS_FLAG   = 8'h10;
   localparam logic [7:0] OFS_SWEV   = 8'h14;
   localparam logic [7:0] OFS_CHCTL0 = 8'h18;
   localparam logic [7:0] OFS_CHCTL1 = 8'h1C;
   localparam logic [7:0] OFS_CHEN   = 8'h20;
   localparam logic [7:0] OFS_CNT    = 8'h24;
   localparam logic [7:0] OFS_PSC    = 8'h28;
   localparam logic [7:0] OFS_CAR    = 8'h2C;
   localparam logic [7:0] OFS_CV0    = 8'h34;
   localparam logic [7:0] CV_STEP    = 8'h04;
   localparam logic [7:0] OFS_BRK    = 8'h44;

   // Event positions, shared by request, flag and enable registers
   localparam int EV_UP   = 0;
   localparam int EV_CH0  = 1;
   localparam int EV_CMT  = 5;
   localparam int EV_TRG  = 6;
   localparam int EV_BRK  = 7;
   localparam int EV_N    = 8;
   localparam int OF_LSB  = 9;
   localparam int FLAG_W  = 13;
   localparam int NCH     = 4;
   localparam int DMA_LSB = 8;
   localparam logic [12:0] FLAG_MASK = 13'h1EFF;

   // Control fields
   localparam int CTL_CEN     = 0;
   localparam int CTL_DIR     = 4;
   localparam int CTL_CAM     = 5;
   localparam int CTL1_SHADOW = 0;
   localparam int BRK_OUT_EN  = 0;

   // Channel control layout: two channels per register
   localparam int CH_STRIDE = 8;
   localparam int CH_MS     = 0;
   localparam int CH_CMP    = 4;
   localparam logic [1:0] MS_OUT = 2'h0;

   // Widths and reset values
   localparam int CNT_W = 16;
   localparam logic [7:0]  RST_CTL  = 8'h00;
   localparam logic [15:0] RST_REG  = 16'h0000;
   localparam logic [15:0] RST_CAR  = 16'hFFFF;
   localparam logic [12:0] RST_FLAG = 13'h0000;

   // Bus slave states
   typedef enum logic [0:0] {
      BUS_ADDR = 1'h0,
      BUS_RDAT = 1'h1
   } bus_state_t;
endpackage

// File: verilog/timer_count_core.sv
// Counter with prescaler, reinitialised by the software update request
`timescale 1ns/100ps
module timer_count_core
   import timer_evt_pkg::*;
(
   input  wire logic             hclk,        // Kernel clock
   input  wire logic             hresetn,     // Async reset, active low
   input  wire logic             count_en,    // Counter running
   input  wire logic             count_down,  // Direction in edge mode
   input  wire logic [1:0]       center_mode, // Nonzero selects center-aligned
   input  wire logic [CNT_W-1:0] psc,         // Prescaler divide value minus one
   input  wire logic [CNT_W-1:0] car,         // Auto-reload value
   input  wire logic             reload,      // Update request pulse
   output logic      [CNT_W-1:0] count,       // Counter value
   output logic                  wrap         // Overflow pulse
);
   logic [CNT_W-1:0] pcnt;
   logic             cdown;
   logic             tick;

   assign tick = count_en && (pcnt == psc);

   // Prescaler; restarts with the counter so the first period is whole
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pcnt <= '0;
      end else if (reload) begin
         pcnt <= '0;
      end else if (tick) begin
         pcnt <= '0;
      end else if (count_en) begin
         pcnt <= pcnt + 1'h1;
      end
   end

   // Main counter; reload beats any tick in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= '0;
         cdown <= 1'h0;
         wrap  <= 1'h0;
      end else begin
         wrap <= 1'h0;
         if (reload) begin
            count <= (center_mode == 2'h0 && count_down) ? car : '0;
            cdown <= 1'h0;
         end else if (tick) begin
            if (center_mode != 2'h0) begin
               if (!cdown && count == car) begin
                  cdown <= 1'h1;
                  count <= count - 1'h1;
                  wrap  <= 1'h1;
               end else if (cdown && count == '0) begin
                  cdown <= 1'h0;
                  count <= count + 1'h1;
                  wrap  <= 1'h1;
               end else begin
                  count <= cdown ? count - 1'h1 : count + 1'h1;
               end
            end else if (count_down) begin
               count <= (count == '0) ? car : count - 1'h1;
               wrap  <= (count == '0);
            end else begin
               count <= (count == car) ? '0 : count + 1'h1;
               wrap  <= (count == car);
            end
         end
      end
   end

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   psc_cleared_a: assert property (reload |=> pcnt == '0)
      else $error("prescaler not cleared by update request");
   reload_value_a: assert property (
      reload |=> count == (($past(center_mode) == 2'h0 && $past(count_down)) ? $past(car) : '0))
      else $error("counter not reinitialised by update request");
endmodule

// File: verilog/timer_software_event_generation.sv
// Timer software event generation with its AHB-Lite register slave
// Functional notes
// - A break request clears the primary output enable, sets the break flag and may interrupt.
// - A trigger request sets the trigger flag and may raise an interrupt or DMA request.
// - A commutation request loads the channel enables and compare controls per shadow select.
// - A channel 0 request sets the channel 0 flag and may raise an interrupt or DMA request.
// - A channel request in input mode captures the counter, and sets over-capture if flagged.
// - Channels 1 to 3 have the same request at bits 2 to 4.
// - An update request clears the counter, or loads the auto-reload value when counting down in edge mode.
// - An update request also clears the prescaler counter in the same cycle.
// - Request bits are set only by a write and cleared by hardware once the event is made.
// - Mode select 00 is output, other codes input; it changes only while the channel is off.
`timescale 1ns/100ps
module timer_software_event_generation
   import timer_evt_pkg::*;
(
   input  wire logic               hclk,                // Kernel clock, 25 MHz
   input  wire logic               hresetn,             // Async reset, active low
   input  wire logic               hsel,                // Slave select
   input  wire logic [31:0]        haddr,               // Byte address
   input  wire logic [1:0]         htrans,              // Transfer type
   input  wire logic               hwrite,              // Write when high
   input  wire logic [2:0]         hsize,               // Word transfers only
   input  wire logic [31:0]        hwdata,              // Write data
   input  wire logic               hready,              // Bus ready
   output logic      [31:0]        hrdata,              // Read data
   output logic                    hreadyout,           // Slave ready
   output logic                    hresp,               // Always OKAY
   output logic                    irq,                 // Level interrupt
   output logic                    dma_req,             // Level DMA request
   output logic                    primary_output_enable,          // Main output gate
   output logic      [NCH-1:0]     channel_output_enable,          // Active enables
   output logic      [NCH-1:0]     channel_complement_enable,      // Active comp. enables
   output logic      [3*NCH-1:0]   channel_compare_output_control  // Active modes
);
   bus_state_t       bstate;
   logic             wr_pend;
   logic [7:0]       ph_addr;
   logic             acc;
   logic [7:0]       ctl;
   logic             shadow_sel;
   logic [15:0]      inten;
   logic [FLAG_W-1:0] flag;
   logic [FLAG_W-1:0] flag_set;
   logic [FLAG_W-1:0] flag_clr;
   logic [FLAG_W-1:0] next_flag;
   logic [EV_N-1:0]  swev;
   logic             swev_wr;
   logic [15:0]      chctl0;
   logic [15:0]      chctl1;
   logic [2*NCH-1:0] chen;
   logic [CNT_W-1:0] psc;
   logic [CNT_W-1:0] car;
   logic [CNT_W-1:0] cv [NCH];
   logic [CNT_W-1:0] count;
   logic             wrap;
   logic [NCH-1:0]   in_mode;
   logic [3*NCH-1:0] comctl_sh;
   logic [31:0]      rd_mux;

   // Word address match; upper address bits alias onto the block
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a[7:2] == ofs[7:2];
   endfunction

   // Field of channel i within the two channel control registers
   function automatic logic [2:0] ch_field(input logic [15:0] c0, input logic [15:0] c1,
                                           input int i, input int lsb);
      logic [15:0] sel;
      sel = (i < 2) ? c0 : c1;
      return sel[CH_STRIDE*(i%2)+lsb +: 3];
   endfunction

   assign acc = hsel && htrans[1] && hready;
   assign swev_wr = wr_pend && hit(ph_addr, OFS_SWEV);

   // Address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'h0;
         ph_addr <= 8'h00;
      end else begin
         wr_pend <= acc && hwrite;
         if (acc) begin
            ph_addr <= haddr[7:0];
         end
      end
   end

   // Reads take one wait state so a write just before is already visible
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bstate    <= BUS_ADDR;
         hreadyout <= 1'h1;
         hrdata    <= 32'h0000_0000;
         hresp     <= 1'h0;
      end else begin
         hresp <= 1'h0;
         unique case (bstate)
            BUS_ADDR: begin
               if (acc && !hwrite) begin
                  bstate    <= BUS_RDAT;
                  hreadyout <= 1'h0;
               end
            end
            BUS_RDAT: begin
               hrdata    <= rd_mux;
               hreadyout <= 1'h1;
               bstate    <= BUS_ADDR;
            end
         endcase
      end
   end

   // Read decode; unmapped words and the request register read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (ph_addr[7:2])
         OFS_CTL[7:2]:    rd_mux[7:0] = ctl;
         OFS_CTL1[7:2]:   rd_mux[CTL1_SHADOW] = shadow_sel;
         OFS_INTEN[7:2]:  rd_mux[15:0] = inten;
         OFS_FLAG[7:2]:   rd_mux[FLAG_W-1:0] = flag;
         OFS_CHCTL0[7:2]: rd_mux[15:0] = chctl0;
         OFS_CHCTL1[7:2]: rd_mux[15:0] = chctl1;
         OFS_CHEN[7:2]:   rd_mux[2*NCH-1:0] = chen;
         OFS_CNT[7:2]:    rd_mux[CNT_W-1:0] = count;
         OFS_PSC[7:2]:    rd_mux[CNT_W-1:0] = psc;
         OFS_CAR[7:2]:    rd_mux[CNT_W-1:0] = car;
         OFS_BRK[7:2]:    rd_mux[BRK_OUT_EN] = primary_output_enable;
         default:         rd_mux = 32'h0000_0000;
      endcase
      for (int i = 0; i < NCH; i++) begin
         if (hit(ph_addr, OFS_CV0 + 8'(CV_STEP * i))) begin
            rd_mux = {16'h0000, cv[i]};
         end
      end
   end

   // Plain control registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctl   <= RST_CTL;
         shadow_sel <= 1'h0;
         inten <= RST_REG;
         chen  <= RST_CTL;
         psc   <= RST_REG;
         car   <= RST_CAR;
      end else if (wr_pend) begin
         if (hit(ph_addr, OFS_CTL))   ctl   <= hwdata[7:0];
         if (hit(ph_addr, OFS_CTL1))  shadow_sel <= hwdata[CTL1_SHADOW];
         if (hit(ph_addr, OFS_INTEN)) inten <= hwdata[15:0];
         if (hit(ph_addr, OFS_CHEN))  chen  <= hwdata[2*NCH-1:0];
         if (hit(ph_addr, OFS_PSC))   psc   <= hwdata[CNT_W-1:0];
         if (hit(ph_addr, OFS_CAR))   car   <= hwdata[CNT_W-1:0];
      end
   end

   // Channel control; a running channel keeps its mode select
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chctl0 <= RST_REG;
         chctl1 <= RST_REG;
      end else if (wr_pend) begin
         if (hit(ph_addr, OFS_CHCTL0)) begin
            chctl0 <= hwdata[15:0];
            if (channel_output_enable[0]) chctl0[1:0] <= chctl0[1:0];
            if (channel_output_enable[1]) chctl0[9:8] <= chctl0[9:8];
         end
         if (hit(ph_addr, OFS_CHCTL1)) begin
            chctl1 <= hwdata[15:0];
            if (channel_output_enable[2]) chctl1[1:0] <= chctl1[1:0];
            if (channel_output_enable[3]) chctl1[9:8] <= chctl1[9:8];
         end
      end
   end

   // Request bits live one cycle: written, acted on, then gone
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         swev <= 8'h00;
      end else if (swev_wr) begin
         swev <= hwdata[EV_N-1:0];
      end else begin
         swev <= 8'h00;
      end
   end

   // Per-channel mode and shadow compare control
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      logic [2:0] mode_sel;
      assign mode_sel = ch_field(chctl0, chctl1, i, CH_MS);
      assign in_mode[i] = mode_sel[1:0] != MS_OUT;
      assign comctl_sh[3*i +: 3] = ch_field(chctl0, chctl1, i, CH_CMP);
      // Over-capture only when the flag is still up from before
      assign flag_set[OF_LSB+i] = swev[EV_CH0+i] && in_mode[i]
                                  && flag[EV_CH0+i];
   end

   // Capture beats a software write to the same value register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < NCH; i++) cv[i] <= RST_REG;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (swev[EV_CH0+i] && in_mode[i]) begin
               cv[i] <= count;
            end else if (wr_pend && hit(ph_addr, OFS_CV0 + 8'(CV_STEP * i))) begin
               cv[i] <= hwdata[CNT_W-1:0];
            end
         end
      end
   end

   // Flag sources; bit 8 stays zero through the mask
   assign flag_set[EV_N-1:0] = {swev[EV_N-1:1], swev[EV_UP] | wrap};
   assign flag_set[EV_N] = 1'h0;
   assign flag_clr = (wr_pend && hit(ph_addr, OFS_FLAG)) ? hwdata[FLAG_W-1:0] : RST_FLAG;
   // Set wins over a write-one clear in the same cycle
   assign next_flag = ((flag & ~flag_clr) | flag_set) & FLAG_MASK;

   // Flags and the request outputs, which follow the flags without lag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag    <= RST_FLAG;
         irq     <= 1'h0;
         dma_req <= 1'h0;
      end else begin
         flag    <= next_flag;
         irq     <= |(next_flag[EV_N-1:0] & inten[EV_N-1:0])
                    | |(next_flag[FLAG_W-1:OF_LSB] & inten[EV_CH0 +: NCH]);
         dma_req <= |(next_flag[EV_N-1:0] & inten[DMA_LSB +: EV_N]);
      end
   end

   // Break drops the output gate; it beats a software set
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         primary_output_enable <= 1'h0;
      end else if (swev[EV_BRK]) begin
         primary_output_enable <= 1'h0;
      end else if (wr_pend && hit(ph_addr, OFS_BRK)) begin
         primary_output_enable <= hwdata[BRK_OUT_EN];
      end
   end

   // Active channel controls: held until commutation when shadowed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         channel_output_enable          <= 4'h0;
         channel_complement_enable      <= 4'h0;
         channel_compare_output_control <= 12'h000;
      end else if (!shadow_sel || swev[EV_CMT]) begin
         for (int i = 0; i < NCH; i++) begin
            channel_output_enable[i]     <= chen[2*i];
            channel_complement_enable[i] <= chen[2*i+1];
         end
         channel_compare_output_control <= comctl_sh;
      end
   end

   timer_count_core u_core (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .count_en    (ctl[CTL_CEN]),
      .count_down  (ctl[CTL_DIR]),
      .center_mode (ctl[CTL_CAM +: 2]),
      .psc         (psc),
      .car         (car),
      .reload      (swev[EV_UP]),
      .count       (count),
      .wrap        (wrap)
   );

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence rd_start;
      acc && !hwrite;
   endsequence
   sequence rd_answer;
      !hreadyout ##1 hreadyout;
   endsequence
   sequence req_write;
      swev_wr && hwdata[EV_N-1:0] != 8'h00;
   endsequence

   read_wait_a: assert property (rd_start |=> rd_answer)
      else $error("read answer not after one wait state");
   break_event_a: assert property (
      swev[EV_BRK] |=> !primary_output_enable && flag[EV_BRK])
      else $error("break request did not clear gate or set flag");
   trigger_flag_a: assert property (
      swev[EV_TRG] |=> flag[EV_TRG] && (irq || !inten[EV_TRG]))
      else $error("trigger request did not set flag or interrupt");
   commutation_load_a: assert property (
      swev[EV_CMT] |=> channel_compare_output_control == $past(comctl_sh))
      else $error("commutation did not load compare control");
   channel_flag_a: assert property (swev[EV_CH0] |=> flag[EV_CH0])
      else $error("channel 0 request did not set flag");
   capture_value_a: assert property (
      swev[EV_CH0] && in_mode[0] |=> cv[0] == $past(count))
      else $error("channel 0 capture value wrong");
   overcapture_flag_a: assert property (
      swev[EV_CH0+2] && in_mode[2] && flag[EV_CH0+2] |=> flag[OF_LSB+2])
      else $error("channel 2 over-capture flag not set");
   request_clear_a: assert property (
      req_write ##1 !swev_wr |=> swev == 8'h00)
      else $error("request bits not cleared by hardware");
   zero_write_a: assert property (
      swev_wr && hwdata[EV_N-1:0] == 8'h00 |=> (swev == 8'h00) [*2])
      else $error("zero write raised a request");
   mode_locked_a: assert property (
      wr_pend && hit(ph_addr, OFS_CHCTL0) && channel_output_enable[0]
      |=> chctl0[1:0] == $past(chctl0[1:0]))
      else $error("mode select changed while channel enabled");

   // Side effects of requests one edge after they act, plus bus response, idle request and mode lock checks
   for (genvar i = 1; i < NCH; i++) begin : g_chk
      chan_flag_a: assert property (swev[EV_CH0+i] |=> flag[EV_CH0+i])
         else $error("channel request did not set its flag");
   end
   okay_resp_a: assert property (!hresp)
      else $error("slave answered other than okay");
   request_idle_a: assert property (!swev_wr |=> swev == 8'h00)
      else $error("request bit raised without a write");
   break_irq_a: assert property (
      swev[EV_BRK] && inten[EV_BRK] |=> irq)
      else $error("break request did not interrupt");
   trigger_dma_a: assert property (
      swev[EV_TRG] && inten[DMA_LSB+EV_TRG] |=> dma_req)
      else $error("trigger request did not raise its DMA request");
   channel_irq_a: assert property (
      swev[EV_CH0] && inten[EV_CH0] |=> irq)
      else $error("channel 0 request did not interrupt");
   commutation_enable_a: assert property (
      swev[EV_CMT] |=> channel_output_enable[0] == $past(chen[0])
         && channel_complement_enable[0] == $past(chen[1]))
      else $error("commutation did not load channel 0 enables");
   output_hold_a: assert property (
      swev[EV_CH0] && !in_mode[0] && !(wr_pend && hit(ph_addr, OFS_CV0))
      |=> cv[0] == $past(cv[0]))
      else $error("output channel captured the counter");
   capture_ch1_a: assert property (
      swev[EV_CH0+1] && in_mode[1] |=> cv[1] == $past(count))
      else $error("channel 1 capture value wrong");
   mode_locked1_a: assert property (
      wr_pend && hit(ph_addr, OFS_CHCTL0) && channel_output_enable[1]
      |=> chctl0[9:8] == $past(chctl0[9:8]))
      else $error("channel 1 mode select changed while enabled");
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the timer software event block over AHB-Lite
`timescale 1ns/100ps
module tb_top
   import timer_evt_pkg::*;
;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        irq;
   logic        dma_req;
   logic        out_gate;
   logic [3:0]  ch_en;
   logic [3:0]  ch_comp;
   logic [11:0] ch_cmp;
   logic [31:0] rdata;
   logic [7:0]  modes [4];
   int          fails;
   int          n_checks;

   // The one slave drives the bus ready
   timer_software_event_generation timer_software_event_generation_inst (
      .hclk                           (hclk),
      .hresetn                        (hresetn),
      .hsel                           (hsel),
      .haddr                          (haddr),
      .htrans                         (htrans),
      .hwrite                         (hwrite),
      .hsize                          (hsize),
      .hwdata                         (hwdata),
      .hready                         (hreadyout),
      .hrdata                         (hrdata),
      .hreadyout                      (hreadyout),
      .hresp                          (hresp),
      .irq                            (irq),
      .dma_req                        (dma_req),
      .primary_output_enable          (out_gate),
      .channel_output_enable          (ch_en),
      .channel_complement_enable      (ch_comp),
      .channel_compare_output_control (ch_cmp)
   );

   // Kernel clock, 40 ns period
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Values are taken right after the edge, so they are the ones the edge sampled
   task automatic wait_ready;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            fails++;
            end_of_test();
         end
         @(posedge hclk);
      end
   endtask

   // One single transfer; caller stands just after a rising edge
   task automatic bus(input logic [7:0] ofs, input logic wr, input logic [31:0] wd);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, ofs};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rdata = hrdata;
   endtask

   task automatic wr(input logic [7:0] ofs, input logic [31:0] wd);
      bus(ofs, 1'b1, wd);
   endtask

   task automatic rd(input logic [7:0] ofs, input logic [31:0] exp);
      bus(ofs, 1'b0, 32'h00000000);
      chk(rdata, exp);
   endtask

   // Events show two edges after the write data phase; levels are stable then
   task automatic settle;
      repeat (2) @(posedge hclk);
   endtask

   // Hang guard, well above the longest sequence
   initial begin
      repeat (20000) @(posedge hclk);
      fails++;
      end_of_test();
   end

   // Main sequence
   initial begin
      fails = 0;
      n_checks = 0;
      modes = '{8'h10, 8'h20, 8'h10, 8'h00};
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk({28'h0, hresp, out_gate, irq, dma_req}, 32'h0);
      rd(OFS_SWEV, 32'h0);
      rd(OFS_CHCTL0, 32'h0);
      rd(8'h08, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      // Break drops the output gate and interrupts when enabled
      wr(OFS_BRK, 32'h1);
      wr(OFS_INTEN, 32'h80);
      settle();
      chk({31'h0, out_gate}, 32'h1);
      wr(OFS_SWEV, 32'h80);
      settle();
      chk({30'h0, out_gate, irq}, 32'h1);
      rd(OFS_FLAG, 32'h80);
      rd(OFS_SWEV, 32'h0);
      wr(OFS_FLAG, 32'h80);
      settle();
      chk({31'h0, irq}, 32'h0);
      // A zero write must leave every flag alone
      wr(OFS_SWEV, 32'h0);
      rd(OFS_FLAG, 32'h0);
      // Trigger with only its DMA enable: masked interrupt, live DMA
      wr(OFS_INTEN, 32'h4000);
      wr(OFS_SWEV, 32'h40);
      settle();
      chk({30'h0, irq, dma_req}, 32'h1);
      rd(OFS_FLAG, 32'h40);
      wr(OFS_FLAG, 32'h40);
      settle();
      chk({31'h0, dma_req}, 32'h0);
      // Shadow select set: enables and compare control wait for commutation
      wr(OFS_CTL1, 32'h1);
      wr(OFS_CHCTL0, 32'h150);
      rd(OFS_CHCTL0, 32'h150);
      wr(OFS_CHEN, 32'h1);
      settle();
      chk({29'h0, ch_cmp[2:0]} | {ch_en, 4'h0}, 32'h0);
      wr(OFS_SWEV, 32'h20);
      settle();
      chk({25'h0, ch_en, ch_cmp[2:0]}, 32'h0D);
      rd(OFS_FLAG, 32'h20);
      wr(OFS_CTL1, 32'h0);
      wr(OFS_CHEN, 32'h3);
      settle();
      chk({28'h0, ch_comp}, 32'h1);
      // Update in each direction with the counter stopped
      wr(OFS_CAR, 32'h1234);
      for (int i = 0; i < 4; i++) begin
         wr(OFS_CTL, {24'h0, modes[i]});
         wr(OFS_SWEV, 32'h1);
         rd(OFS_CNT, modes[i][4] ? 32'h1234 : 32'h0);
      end
      rd(OFS_FLAG, 32'h21);
      // Channel 1 in input mode captures; a second hit flags over-capture
      wr(OFS_CTL, 32'h10);
      wr(OFS_SWEV, 32'h1);
      wr(OFS_FLAG, 32'h1FFF);
      wr(OFS_SWEV, 32'h4);
      rd(OFS_CV0 + CV_STEP, 32'h1234);
      rd(OFS_FLAG, 32'h4);
      wr(OFS_SWEV, 32'h4);
      rd(OFS_FLAG, 32'h404);
      // Channel 0 is an output, so nothing is captured
      wr(OFS_FLAG, 32'h1FFF);
      wr(OFS_SWEV, 32'h2);
      rd(OFS_CV0, 32'h0);
      rd(OFS_FLAG, 32'h2);
      // Several bits at once, then back-to-back single requests
      wr(OFS_FLAG, 32'h1FFF);
      wr(OFS_SWEV, 32'h5E);
      rd(OFS_FLAG, 32'h5E);
      wr(OFS_FLAG, 32'h1FFF);
      wr(OFS_SWEV, 32'h8);
      wr(OFS_SWEV, 32'h10);
      rd(OFS_FLAG, 32'h18);
      rd(OFS_SWEV, 32'h0);
      // Running counter, divide by four: the update must restart the prescaler phase
      wr(OFS_PSC, 32'h3);
      wr(OFS_CTL, 32'h1);
      repeat (3) @(posedge hclk);
      wr(OFS_SWEV, 32'h1);
      rd(OFS_CNT, 32'h0);
      rd(OFS_CNT, 32'h0);
      rd(OFS_CNT, 32'h1);
      end_of_test();
   end
endmodule
